// file: design/decode_if.sv
// carries one cpu address and the current mode settings to the page 0
// decoder and brings the region selects back; purely combinational
`timescale 1ns/1ps
`default_nettype none

interface decode_if;
  logic [19:0] addr;
  logic [2:0] mode;
  logic ram_en;
  logic fetch;
  logic sel_rom;
  logic sel_ram;
  logic sel_reg;
  logic sel_ext;
  logic addr_err;
  logic fetch_err;

  modport requester (
    output addr, mode, ram_en, fetch,
    input sel_rom, sel_ram, sel_reg, sel_ext, addr_err, fetch_err
  );

  modport decoder (
    input addr, mode, ram_en, fetch,
    output sel_rom, sel_ram, sel_reg, sel_ext, addr_err, fetch_err
  );
endinterface

`default_nettype wire

// file: design/mode_decode_pkg.sv
// constants shared by the mode latch, the page 0 decoder and the top level
// assumes a byte-addressed cpu with 20 address bits and registers in page 0
package mode_decode_pkg;

  // mode pin codes that the board may present
  localparam logic [2:0] MODE_1 = 3'h1;
  localparam logic [2:0] MODE_2 = 3'h2;
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_7 = 3'h7;

  // register field and on-chip memory ranges in page 0
  localparam logic [15:0] REG_FIELD_LO = 16'hff80;
  localparam logic [15:0] REG_FIELD_HI = 16'hffff;
  localparam logic [15:0] RAM_LO = 16'hfb80;
  localparam logic [15:0] RAM_HI = 16'hff7f;
  localparam logic [15:0] ROM_HI = 16'h7fff;
  localparam logic [3:0] PAGE_ZERO = 4'h0;

  // register locations
  localparam logic [15:0] PORT5_DIR_ADDR = 16'hff88;
  localparam logic [15:0] PORT6_DIR_ADDR = 16'hff89;
  localparam logic [15:0] RAM_CONTROL_ADDR = 16'hfff9;
  localparam logic [15:0] MODE_CONTROL_ADDR = 16'hfffa;

  // field positions and fixed bits
  localparam int RAM_ENABLE_BIT = 7;
  localparam logic [4:0] MODE_CONTROL_FIXED = 5'h18;

  // values after reset
  localparam logic RAM_ENABLE_RESET = 1'b1;
  localparam logic [7:0] PORT_DIR_RESET = 8'h00;
  localparam logic [2:0] MODE_RESET = 3'h0;

  // synchroniser depth for the mode pins
  localparam int SYNC_STAGES = 2;

endpackage

// file: design/mode_pin_sync.sv
// two-stage synchroniser for the three mode pins
// assumes the pins are static board straps, asynchronous to mclk
`timescale 1ns/1ps
`default_nettype none

module mode_pin_sync (
  // clock
  input wire logic mclk,
  // pins and synchronised copy
  input wire logic [2:0] pins,
  output logic [2:0] pins_sync
);

  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] stable;
  } sync_state_type;

  sync_state_type st_r;
  sync_state_type st_nxt;

  // no reset here: a reset would have to load a pin value, and the
  // capture happens after release anyway
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = pins;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge mclk) begin
    st_r <= st_nxt;
  end

  assign pins_sync = st_r.stable;

endmodule

`default_nettype wire

// file: design/mode_select_address_decoder.sv
// mode latch, page 0 memory map and bus port assignment
// assumes a cpu that presents one access per request and mode straps on pins
//
// Functional notes
// - mode 1: 64K space, no on-chip rom
// - mode 2: 64K, low 32K on-chip rom
// - mode 3: 1M space, no on-chip rom
// - mode 4: 1M, low 32K on-chip rom
// - minimum modes: ports 1-2 control, 3 data, 4-5 address
// - maximum modes: ports 4, 5, 6 address
// - mode 2: port 5 input until software
// - mode 4: ports 5, 6 input until direction written
// - mode 7: only on-chip rom and ram
// - single-chip releases bus pins as gpio
// - 64K pages; maximum modes up to 16
// - vectors from rom in modes 2, 4
// - top 128 page 0 addresses are registers
// - ram enable, reset one, maps on-chip ram
// - ram disabled: range goes external
// - ram enable is bit 7 at fff9
// - single-chip, ram disabled: range gives error
// - mode register captures pins at reset release
// - mode register bits 7-6 one, 5-3 zero
// - mode register low bits mirror pins
// - mode pins select minimum or maximum
// - modes 1-2 minimum, 3-4 maximum
`timescale 1ns/1ps
`default_nettype none

module mode_select_address_decoder (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // mode strap pins
  input wire logic mode_pin2,
  input wire logic mode_pin1,
  input wire logic mode_pin0,
  // cpu access
  input wire logic acc_req,
  input wire logic acc_wr,
  input wire logic acc_word,
  input wire logic acc_fetch,
  input wire logic acc_vector,
  input wire logic [19:0] acc_addr,
  input wire logic [15:0] acc_wdata,
  // access answer
  output logic acc_done,
  output logic sel_rom,
  output logic sel_ram,
  output logic sel_reg,
  output logic sel_ext,
  output logic addr_error,
  output logic fetch_error,
  output logic vector_onchip,
  output logic [15:0] rd_data,
  // mode state
  output logic [2:0] mode_latch,
  output logic max_mode,
  output logic expanded_mode,
  output logic mode_invalid,
  output logic ram_enabled,
  // port functions
  output logic ctrl_port_en,
  output logic data_port_en,
  output logic port4_addr_en,
  output logic [7:0] port5_addr_oe,
  output logic [7:0] port6_addr_oe,
  output logic gpio_release
);

  typedef struct packed {
    logic cap_pend;
    logic [2:0] mode;
    logic ram_en;
    logic [7:0] port5_dir;
    logic [7:0] port6_dir;
    logic done;
    logic rom;
    logic ram;
    logic reg_hit;
    logic ext;
    logic aerr;
    logic ferr;
    logic vec_rom;
    logic [15:0] rdata;
    logic maxm;
    logic expm;
    logic invalid;
    logic ctrl_en;
    logic data_en;
    logic p4_en;
    logic [7:0] p5_oe;
    logic [7:0] p6_oe;
    logic gpio;
  } top_state_type;

  top_state_type st_r;
  top_state_type st_nxt;

  logic [2:0] pins_sync;
  decode_if dbus ();

  mode_pin_sync u_sync (
    .mclk(mclk),
    .pins({mode_pin2, mode_pin1, mode_pin0}),
    .pins_sync(pins_sync)
  );

  page0_decoder u_dec (
    .dec(dbus)
  );

  // byte view of the register field at one location
  function automatic logic [7:0] reg_byte(input logic [15:0] a, input top_state_type s);
    reg_byte = 8'h00;
    if (a == mode_decode_pkg::MODE_CONTROL_ADDR) begin
      reg_byte = {mode_decode_pkg::MODE_CONTROL_FIXED, s.mode};
    end else if (a == mode_decode_pkg::RAM_CONTROL_ADDR) begin
      reg_byte = 8'h00;
      reg_byte[mode_decode_pkg::RAM_ENABLE_BIT] = s.ram_en;
    end else if (a == mode_decode_pkg::PORT5_DIR_ADDR) begin
      reg_byte = s.port5_dir;
    end else if (a == mode_decode_pkg::PORT6_DIR_ADDR) begin
      reg_byte = s.port6_dir;
    end
  endfunction

  function automatic logic is_max(input logic [2:0] m);
    is_max = (m == mode_decode_pkg::MODE_3) || (m == mode_decode_pkg::MODE_4);
  endfunction

  function automatic logic is_min(input logic [2:0] m);
    is_min = (m == mode_decode_pkg::MODE_1) || (m == mode_decode_pkg::MODE_2);
  endfunction

  // codes the board is allowed to strap; anything else is reported, and only the register field and ram still decode
  function automatic logic is_legal(input logic [2:0] m);
    is_legal = is_min(m) || is_max(m) || (m == mode_decode_pkg::MODE_7);
  endfunction

  // single-chip has rom too, but its vector tables are not taken from it
  function automatic logic vec_from_rom(input logic [2:0] m);
    vec_from_rom = (m == mode_decode_pkg::MODE_2) || (m == mode_decode_pkg::MODE_4);
  endfunction

  // address drive of one pin of port 5 or 6; modes 2 and 4 wait for software
  function automatic logic pin_drive(input logic [2:0] m, input logic dir, input logic port6);
    pin_drive = 1'b0;
    unique case (m)
      mode_decode_pkg::MODE_1: begin
        pin_drive = !port6;
      end
      mode_decode_pkg::MODE_2: begin
        // rom holds the low half, so port 5 starts out as plain input
        pin_drive = !port6 && dir;
      end
      mode_decode_pkg::MODE_3: begin
        pin_drive = 1'b1;
      end
      mode_decode_pkg::MODE_4: begin
        pin_drive = dir;
      end
      default: begin
        // single-chip and illegal codes keep every bus pin off
        pin_drive = 1'b0;
      end
    endcase
  endfunction

  logic [15:0] a_hi;
  logic [15:0] a_lo;
  logic reg_wr;
  logic expm;
  logic maxm;
  logic [7:0] p5_drive;
  logic [7:0] p6_drive;

  // one decision per pin: a partly written direction register drives only its own pins
  for (genvar g = 0; g < 8; g++) begin : g_pin
    assign p5_drive[g] = pin_drive(st_r.mode, st_r.port5_dir[g], 1'b0);
    assign p6_drive[g] = pin_drive(st_r.mode, st_r.port6_dir[g], 1'b1);
  end

  always_comb begin
    dbus.addr = acc_addr;
    dbus.mode = st_r.mode;
    dbus.ram_en = st_r.ram_en;
    dbus.fetch = acc_fetch;
  end

  always_comb begin
    st_nxt = st_r;
    // word accesses ignore address bit 0; high byte sits at the even location
    a_hi = acc_word ? {acc_addr[15:1], 1'b0} : acc_addr[15:0];
    a_lo = {acc_addr[15:1], 1'b1};
    reg_wr = acc_req && acc_wr && dbus.sel_reg && !acc_fetch;
    maxm = is_max(st_r.mode);
    expm = maxm || is_min(st_r.mode);

    // capture once, on the first edge after reset release, then hold
    if (st_r.cap_pend) begin
      st_nxt.mode = pins_sync;
      st_nxt.cap_pend = 1'b0;
    end
    // no other path writes the mode field, so pin changes are ignored

    // register writes; the mode register simply has no write path
    if (reg_wr) begin
      if (acc_word) begin
        if (a_lo == mode_decode_pkg::RAM_CONTROL_ADDR) begin
          st_nxt.ram_en = acc_wdata[mode_decode_pkg::RAM_ENABLE_BIT];
        end
        if (a_hi == mode_decode_pkg::PORT5_DIR_ADDR) begin
          st_nxt.port5_dir = acc_wdata[15:8];
          st_nxt.port6_dir = acc_wdata[7:0];
        end
      end else begin
        if (a_hi == mode_decode_pkg::RAM_CONTROL_ADDR) begin
          st_nxt.ram_en = acc_wdata[mode_decode_pkg::RAM_ENABLE_BIT];
        end
        if (a_hi == mode_decode_pkg::PORT5_DIR_ADDR) begin
          st_nxt.port5_dir = acc_wdata[7:0];
        end
        if (a_hi == mode_decode_pkg::PORT6_DIR_ADDR) begin
          st_nxt.port6_dir = acc_wdata[7:0];
        end
      end
    end

    // access answer, one cycle after the request
    st_nxt.done = acc_req;
    st_nxt.rom = acc_req && dbus.sel_rom;
    st_nxt.ram = acc_req && dbus.sel_ram;
    st_nxt.reg_hit = acc_req && dbus.sel_reg;
    st_nxt.ext = acc_req && dbus.sel_ext;
    st_nxt.aerr = acc_req && dbus.addr_err;
    st_nxt.ferr = acc_req && dbus.fetch_err;
    // vector tables live in rom only where rom is mapped and not single-chip
    st_nxt.vec_rom = acc_req && acc_vector && vec_from_rom(st_r.mode);
    st_nxt.rdata = 16'h0000;
    if (acc_req && !acc_wr && dbus.sel_reg) begin
      if (acc_word) begin
        st_nxt.rdata = {reg_byte(a_hi, st_r), reg_byte(a_lo, st_r)};
      end else begin
        st_nxt.rdata = {8'h00, reg_byte(a_hi, st_r)};
      end
    end

    // port assignment follows the latched mode
    st_nxt.maxm = maxm;
    st_nxt.expm = expm;
    st_nxt.invalid = !st_r.cap_pend && !is_legal(st_r.mode);
    st_nxt.ctrl_en = expm;
    st_nxt.data_en = expm;
    st_nxt.p4_en = expm;
    // per-pin enables lag the direction write by one cycle
    st_nxt.p5_oe = p5_drive;
    st_nxt.p6_oe = p6_drive;
    st_nxt.gpio = !st_r.cap_pend && (st_r.mode == mode_decode_pkg::MODE_7);
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.cap_pend <= 1'b1;
      st_r.mode <= mode_decode_pkg::MODE_RESET;
      st_r.ram_en <= mode_decode_pkg::RAM_ENABLE_RESET;
      st_r.port5_dir <= mode_decode_pkg::PORT_DIR_RESET;
      st_r.port6_dir <= mode_decode_pkg::PORT_DIR_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // every output is a field of the registered state
  assign acc_done = st_r.done;
  assign sel_rom = st_r.rom;
  assign sel_ram = st_r.ram;
  assign sel_reg = st_r.reg_hit;
  assign sel_ext = st_r.ext;
  assign addr_error = st_r.aerr;
  assign fetch_error = st_r.ferr;
  assign vector_onchip = st_r.vec_rom;
  assign rd_data = st_r.rdata;
  assign mode_latch = st_r.mode;
  assign max_mode = st_r.maxm;
  assign expanded_mode = st_r.expm;
  assign mode_invalid = st_r.invalid;
  assign ram_enabled = st_r.ram_en;
  assign ctrl_port_en = st_r.ctrl_en;
  assign data_port_en = st_r.data_en;
  assign port4_addr_en = st_r.p4_en;
  assign port5_addr_oe = st_r.p5_oe;
  assign port6_addr_oe = st_r.p6_oe;
  assign gpio_release = st_r.gpio;

endmodule

`default_nettype wire

// file: design/page0_decoder.sv
// maps one cpu address onto rom, ram, register field or external bus
// assumes the caller registers the answers; all paths here are combinational
`timescale 1ns/1ps
`default_nettype none

module page0_decoder (
  // request and answer
  decode_if.decoder dec
);

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  logic [15:0] a16;
  logic max_mode;
  logic rom_mapped;
  logic ext_allowed;
  logic page0;
  logic ram_range;

  always_comb begin
    a16 = dec.addr[15:0];
    max_mode = (dec.mode == mode_decode_pkg::MODE_3) || (dec.mode == mode_decode_pkg::MODE_4);
    rom_mapped = (dec.mode == mode_decode_pkg::MODE_2) || (dec.mode == mode_decode_pkg::MODE_4)
                 || (dec.mode == mode_decode_pkg::MODE_7);
    ext_allowed = (dec.mode == mode_decode_pkg::MODE_1) || (dec.mode == mode_decode_pkg::MODE_2)
                  || max_mode;
    // minimum and single-chip modes have no page lines, so upper bits fold away
    page0 = !max_mode || (dec.addr[19:16] == mode_decode_pkg::PAGE_ZERO);
    ram_range = page0 && in_range(a16, mode_decode_pkg::RAM_LO, mode_decode_pkg::RAM_HI);
    dec.sel_reg = page0 && in_range(a16, mode_decode_pkg::REG_FIELD_LO,
                                     mode_decode_pkg::REG_FIELD_HI);
    dec.sel_ram = ram_range && dec.ram_en;
    dec.sel_rom = page0 && rom_mapped && (a16 <= mode_decode_pkg::ROM_HI);
    // disabled ram falls through to the external bus where one exists
    dec.sel_ext = ext_allowed && !dec.sel_reg && !dec.sel_ram && !dec.sel_rom;
    // single-chip never goes off chip; a disabled ram hole is an error there
    dec.addr_err = !ext_allowed && !dec.sel_reg && !dec.sel_ram && !dec.sel_rom;
    dec.fetch_err = dec.fetch && dec.sel_reg;
  end

endmodule

`default_nettype wire

// file: testbench/mode_decode_monitor.sv
// assertions on the mode decoder's answers and mode levels
// assumes it is bound onto the decoder top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module mode_decode_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // access request
  input wire logic acc_req,
  input wire logic acc_wr,
  input wire logic acc_word,
  input wire logic acc_fetch,
  input wire logic acc_vector,
  input wire logic [19:0] acc_addr,
  input wire logic [15:0] acc_wdata,
  // answer
  input wire logic acc_done,
  input wire logic sel_rom,
  input wire logic sel_ram,
  input wire logic sel_ext,
  input wire logic addr_error,
  input wire logic fetch_error,
  input wire logic vector_onchip,
  input wire logic [15:0] rd_data,
  // mode state and ports
  input wire logic [2:0] mode_latch,
  input wire logic max_mode,
  input wire logic ram_enabled,
  input wire logic data_port_en,
  input wire logic gpio_release,
  input wire logic [7:0] port5_addr_oe
);
  logic [1:0] up_r;
  logic up, pg0, rd_req, rom_mode, wbit7;
  logic [7:0] whi;
  // derived levels only settle two edges after release
  always_ff @(posedge mclk) begin
    if (!nrst) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  assign up = up_r == 2'h3;
  assign pg0 = acc_addr[19:16] == 4'h0;
  assign rd_req = up && acc_req && !acc_wr && pg0 && (mode_latch inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h7});
  assign rom_mode = mode_latch inside {3'h2, 3'h4, 3'h7};
  assign wbit7 = acc_wdata[7];
  assign whi = acc_wdata[15:8];
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_done_pulse: assert property (up_r != 2'h0 |-> acc_done == $past(acc_req))
    else $error("acc_done does not follow acc_req");
  a_mode_read: assert property (rd_req && !acc_word && acc_addr[15:0] == 16'hfffa |=> rd_data == {8'h00, 5'h18, mode_latch})
    else $error("mode_control read value wrong");
  a_latch_hold: assert property (up |-> $stable(mode_latch))
    else $error("mode latch moved between resets");
  a_port_levels: assert property (up |-> gpio_release == (mode_latch == 3'h7) && data_port_en == (mode_latch inside {[3'h1:3'h4]}) && max_mode == (mode_latch inside {3'h3, 3'h4}))
    else $error("mode levels wrong");
  a_low_rom: assert property (rd_req && acc_addr[15:0] < 16'h8000 |=> sel_rom == $past(rom_mode) && sel_ext == !$past(rom_mode))
    else $error("low page 0 decode wrong");
  a_ram_range: assert property (rd_req && acc_addr[15:0] inside {[16'hfb80:16'hff7f]} |=> sel_ram == $past(ram_enabled) && addr_error == (!$past(ram_enabled) && $past(mode_latch) == 3'h7) && sel_ext == (!$past(ram_enabled) && $past(mode_latch) != 3'h7))
    else $error("ram range decode wrong");
  a_ram_bit: assert property (up && acc_req && acc_wr && !acc_word && !acc_fetch && pg0 && acc_addr[15:0] == 16'hfff9 |=> ram_enabled == $past(wbit7))
    else $error("ram enable bit not written");
  a_reg_fetch: assert property (up && acc_req && acc_fetch && !acc_wr && pg0 && acc_addr[15:7] == 9'h1ff |=> fetch_error)
    else $error("fetch from register field not flagged");
  a_vector_src: assert property (up && acc_req && acc_vector |=> vector_onchip == ($past(mode_latch) inside {3'h2, 3'h4}))
    else $error("vector source wrong");
  a_port_dir: assert property (up && acc_req && acc_wr && acc_word && pg0 && acc_addr[15:0] == 16'hff88 && (mode_latch inside {3'h2, 3'h4}) |-> ##2 port5_addr_oe == $past(whi, 2))
    else $error("port 5 drive enables do not follow direction write");
  c_mode_read: cover property (rd_req && acc_addr[15:0] == 16'hfffa);
  c_addr_err: cover property (addr_error);
  c_fetch_err: cover property (fetch_error);
endmodule
bind mode_select_address_decoder mode_decode_monitor i_mon (.mclk(mclk), .nrst(nrst), .acc_req(acc_req),
  .acc_wr(acc_wr), .acc_word(acc_word), .acc_fetch(acc_fetch), .acc_vector(acc_vector), .acc_addr(acc_addr),
  .acc_wdata(acc_wdata), .acc_done(acc_done), .sel_rom(sel_rom), .sel_ram(sel_ram), .sel_ext(sel_ext),
  .addr_error(addr_error), .fetch_error(fetch_error), .vector_onchip(vector_onchip), .rd_data(rd_data),
  .mode_latch(mode_latch), .max_mode(max_mode), .ram_enabled(ram_enabled), .data_port_en(data_port_en),
  .gpio_release(gpio_release), .port5_addr_oe(port5_addr_oe));
`default_nettype wire

// file: testbench/strap_board.sv
// board side of the decoder: mode straps and an external memory that counts cycles
// assumes the bench asks for a mode code; only legal codes reach the pins
`timescale 1ns/1ps
`default_nettype none
module strap_board (
  // clock
  input wire logic mclk,
  // requested strap code and bus activity
  input wire logic [2:0] want,
  input wire logic sel_ext,
  // pins and external cycle count
  output logic [2:0] pins,
  output var int ext_cycles
);
  // one process owns the count; the port only mirrors it
  int count_r = 0;
  always_comb ext_cycles = count_r;
  // straps never show codes 0, 5 or 6; single-chip is the safe fallback
  always_comb pins = (want inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h7}) ? want : 3'h7;
  always @(posedge mclk) begin
    if (sel_ext === 1'b1) count_r <= count_r + 1;
  end
endmodule
`default_nettype wire

// file: testbench/test_mode_select_address_decoder.sv
// self-checking bench for the mode decoder: one reset and access pass per legal strap
// assumes the strap board model drives the pins and counts external cycles
`timescale 1ns/1ps
`default_nettype none
module test_mode_select_address_decoder;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic acc_req = 1'b0, acc_wr = 1'b0, acc_word = 1'b0, acc_fetch = 1'b0, acc_vector = 1'b0;
  logic [19:0] acc_addr = 20'h00000;
  logic [15:0] acc_wdata = 16'h0000;
  logic [2:0] want = 3'h1;
  logic [2:0] pins, mode_latch, m;
  int ext_cycles, ext0;
  logic acc_done, sel_rom, sel_ram, sel_reg, sel_ext, addr_error, fetch_error, vector_onchip;
  logic max_mode, expanded_mode, mode_invalid, ram_enabled, ctrl_port_en, data_port_en, port4_addr_en, gpio_release;
  logic [15:0] rd_data, ans_data;
  logic [7:0] port5_addr_oe, port6_addr_oe, ans;
  logic rom, ex, mx, vo;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #12.5 mclk = ~mclk;
  mode_select_address_decoder i_dut (.mclk(mclk), .nrst(nrst), .mode_pin2(pins[2]), .mode_pin1(pins[1]),
    .mode_pin0(pins[0]), .acc_req(acc_req), .acc_wr(acc_wr), .acc_word(acc_word), .acc_fetch(acc_fetch),
    .acc_vector(acc_vector), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_done(acc_done), .sel_rom(sel_rom),
    .sel_ram(sel_ram), .sel_reg(sel_reg), .sel_ext(sel_ext), .addr_error(addr_error), .fetch_error(fetch_error),
    .vector_onchip(vector_onchip), .rd_data(rd_data), .mode_latch(mode_latch), .max_mode(max_mode),
    .expanded_mode(expanded_mode), .mode_invalid(mode_invalid), .ram_enabled(ram_enabled),
    .ctrl_port_en(ctrl_port_en), .data_port_en(data_port_en), .port4_addr_en(port4_addr_en),
    .port5_addr_oe(port5_addr_oe), .port6_addr_oe(port6_addr_oe), .gpio_release(gpio_release));
  strap_board i_board (.mclk(mclk), .want(want), .sel_ext(sel_ext), .pins(pins), .ext_cycles(ext_cycles));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one access; answer flags are captured while they stand
  task automatic acc(input logic wr, word, fetch, vec, input logic [19:0] addr, input logic [15:0] wdata);
    @(posedge mclk);
    #1;
    acc_req = 1'b1;
    acc_wr = wr;
    acc_word = word;
    acc_fetch = fetch;
    acc_vector = vec;
    acc_addr = addr;
    acc_wdata = wdata;
    @(posedge mclk);
    #1;
    acc_req = 1'b0;
    ans = {acc_done, sel_rom, sel_ram, sel_reg, sel_ext, addr_error, fetch_error, vector_onchip};
    ans_data = rd_data;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    for (int i = 0; i < 5; i++) begin
      m = (i == 4) ? 3'h7 : 3'(i + 1);
      rom = m == 3'h2 || m == 3'h4 || m == 3'h7;
      ex = m != 3'h7;
      mx = m == 3'h3 || m == 3'h4;
      vo = m == 3'h2 || m == 3'h4;
      @(posedge mclk);
      #1;
      nrst = 1'b0;
      want = m;
      repeat (5) @(posedge mclk);
      #1;
      nrst = 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      ext0 = ext_cycles;
      // straps moved after capture must not reach the latch
      want = (m == 3'h1) ? 3'h2 : 3'h1;
      acc(0, 0, 0, 0, 20'h0fffa, 16'h0000);
      check({8'h00, ans}, 16'h0090);
      check(ans_data, {8'h00, 5'h18, m});
      check({max_mode, expanded_mode, ctrl_port_en, data_port_en, port4_addr_en, gpio_release, mode_invalid,
        ram_enabled, port5_addr_oe}, {mx, ex, ex, ex, ex, !ex, 2'b01, (m == 3'h1 || m == 3'h3) ? 8'hff : 8'h00});
      check({port6_addr_oe, 5'h00, mode_latch}, {(m == 3'h3) ? 8'hff : 8'h00, 5'h00, m});
      acc(0, 0, 0, 0, 20'h01000, 16'h0000);
      check({8'h00, ans}, {8'h00, 1'b1, rom, 2'b00, !rom, 3'b000});
      acc(0, 0, 0, 1, 20'h00000, 16'h0000);
      check({8'h00, ans}, {8'h00, 1'b1, rom, 2'b00, !rom, 2'b00, vo});
      acc(0, 0, 0, 0, 20'h0fc00, 16'h0000);
      check({8'h00, ans}, 16'h00a0);
      acc(0, 0, 0, 0, 20'h0fff9, 16'h0000);
      check(ans_data, 16'h0080);
      acc(1, 0, 0, 0, 20'h0fff9, 16'h0000);
      check({15'h0000, ram_enabled}, 16'h0000);
      acc(0, 0, 0, 0, 20'h0fc00, 16'h0000);
      check({8'h00, ans}, {8'h00, 4'h8, ex, !ex, 2'b00});
      acc(1, 0, 0, 0, 20'h0fffa, 16'h00ff);
      acc(0, 1, 0, 0, 20'h0fffa, 16'h0000);
      check(ans_data, {5'h18, m, 8'h00});
      acc(0, 0, 1, 0, 20'h0ff90, 16'h0000);
      check({14'h0000, ans[7], ans[1]}, 16'h0003);
      acc(1, 1, 0, 0, 20'h0ff88, 16'hffff);
      @(posedge mclk);
      #1;
      check({port5_addr_oe, port6_addr_oe}, {ex ? 8'hff : 8'h00, mx ? 8'hff : 8'h00});
      check(16'(ext_cycles - ext0), (m == 3'h1 || m == 3'h3) ? 16'h0003 : (ex ? 16'h0001 : 16'h0000));
    end
    stop_test();
  end
endmodule
`default_nettype wire
